// ---- amc_mode_ctrl_regs.sv ----
// Notes on behaviour
// R1 - Mode field: 2 measure, 1 wakeup, 0 power down; resets to power down.
// R2 - External sample bit makes rising edges on pin two trigger samples.
// R3 - External clock bit makes pin one's clock the time base.
// R4 - Wire-mode bit: 1 three-wire serial, 0 four-wire, reset four-wire.
// R5 - Rate codes 0 to 6 give 6.25 to 400 Hz sampling.
// R6 - Filter bit inserts the low pass filter; reset bypasses it.
// R7 - Z, Y, X enable bits gate capture; all reset enabled.
// R8 - Automatic wakeup to measure change raises activity.
// R9 - Automatic measure to wakeup change raises inactivity.
// R10 - Activity routed to pin two by bit 7, pin one by bit 5.
// R11 - Inactivity routed to pin two by bit 6, pin one by bit 4.
// R12 - Polarity bits 3 and 2 make pins two and one active low.
// R13 - Range codes 0 to 3 select 2g, 4g, 8g, 16g full scale.
// R14 - Hold codes 2 to 15 double from 2.5 ms to 20.5 s.
// R15 - Hold code 1 keeps pin asserted until status register read.
// R16 - Hold code 0 gives roughly 25 us pulse.
// R17 - Pin one hold field behaves exactly like pin two's.
// R18 - Idle timer counts 40 ms units of no motion before wakeup.
// R19 - Idle timer is 16 bits, upper and lower byte registers.
// R20 - X low register shows sample bits 3 to 0 in bits 7 to 4.
// R21 - X high register shows sample bits 11 to 4.
// R22 - Reading interrupt status clears all pending sources.
// R23 - Soft reset write restores configuration defaults; bit reads zero.
// R24 - Host reads both X bytes as one burst for coherence; amc_host reads them as two single accesses, and X high is not latched.
`timescale 1ns/10ps
module amc_mode_ctrl_regs import amc_pkg::*; #(
    parameter int RATE_BASE = RATE_BASE_CYC,
    parameter int HOLD_BASE = HOLD_BASE_CYC,
    parameter int IDLE_UNIT = IDLE_UNIT_CYC
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Register access from the serial port.
    input wire amc_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Sensing front end.
    input wire logic motion_detect,
    input wire logic x_sample_valid,
    input wire logic [11:0] x_sample_value,
    output logic sample_strobe,
    output amc_cfg_t cfg,
    // First interrupt pin, also the external clock input.
    input wire logic first_irq_pin_in,
    output logic first_irq_pin_out,
    output logic first_irq_pin_oe,
    // Second interrupt pin, also the external sample trigger input.
    input wire logic second_irq_pin_in,
    output logic second_irq_pin_out,
    output logic second_irq_pin_oe
);

    amc_core_t st_reg;
    amc_core_t st_next;
    logic op_wr;
    logic soft_rst;
    logic status_rd;
    logic clk_edge;
    logic trig_edge;
    logic tick;
    logic [2:0] rate_eff;
    logic [22:0] rate_period;
    logic [15:0] timeout;
    logic act_set;
    logic idle_set;
    logic rate_hit;
    logic [1:0] pin_event;
    logic [1:0] pin_active;
    logic [1:0] pin_pol;
    logic [3:0] hold_sel [2];

    // Decode of the access taken in this cycle.
    assign op_wr = reg_req.wr && (reg_req.addr == ADDR_OP_MODE);
    assign soft_rst = op_wr && reg_req.wdata[SOFT_RESET_BIT];
    assign status_rd = reg_req.rd && (reg_req.addr == ADDR_IRQ_STATUS);

    // Edges use only the second and third synchroniser stages.
    assign clk_edge = st_reg.clk_sync[1] && !st_reg.clk_sync[2];
    assign trig_edge = st_reg.trig_sync[1] && !st_reg.trig_sync[2];

    // R3 - pin clock base
    assign tick = st_reg.op_mode_reg[EXT_CLOCK_BIT] ? clk_edge : 1'b1;

    // R5 - rate to period
    assign rate_eff = (st_reg.rate_reg[6:4] > RATE_MAX_CODE) ? RATE_MAX_CODE :
        st_reg.rate_reg[6:4];
    assign rate_period = (st_reg.op_state == AMC_WAKE) ? (23'(RATE_BASE) << RATE_MAX_CODE) :
        (23'(RATE_BASE) << (RATE_MAX_CODE - rate_eff));

    // R19 - sixteen bit timeout
    assign timeout = {st_reg.idle_hi_reg, st_reg.idle_lo_reg};

    // Route the two mode events and pick polarity and hold per pin.
    // R10 - activity routing
    // R11 - inactivity routing
    assign pin_event[0] = (st_reg.act_flag == 1'b0 && act_set && st_reg.route_reg[ACT_PIN_ONE_BIT])
        || (act_set && st_reg.route_reg[ACT_PIN_ONE_BIT])
        || (idle_set && st_reg.route_reg[IDLE_PIN_ONE_BIT]);
    assign pin_event[1] = (act_set && st_reg.route_reg[ACT_PIN_TWO_BIT])
        || (idle_set && st_reg.route_reg[IDLE_PIN_TWO_BIT]);
    assign pin_pol = {st_reg.route_reg[POL_PIN_TWO_BIT], st_reg.route_reg[POL_PIN_ONE_BIT]};
    assign hold_sel[0] = st_reg.hold_reg[3:0];
    assign hold_sel[1] = st_reg.hold_reg[7:4];

    // R17 - identical pin holds
    for (genvar p = 0; p < 2; p++) begin : g_pin
        amc_pin_hold #(
            .HOLD_BASE(HOLD_BASE)
        ) u_hold (
            .core_clk(core_clk),
            .resetn(resetn),
            .tick(tick),
            .event_in(pin_event[p]),
            .status_clear(status_rd),
            .hold_select(hold_sel[p]),
            .active(pin_active[p])
        );
    end

    // Next state of the whole bank.
    always_comb begin
        st_next = st_reg;
        act_set = 1'b0;
        idle_set = 1'b0;
        rate_hit = 1'b0;
        st_next.sample_strobe = 1'b0;
        st_next.clk_sync = {st_reg.clk_sync[1:0], first_irq_pin_in};
        st_next.trig_sync = {st_reg.trig_sync[1:0], second_irq_pin_in};

        // Register writes; reserved bits are never stored so they read zero.
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_OP_MODE: begin
                    if (reg_req.wdata[SOFT_RESET_BIT]) begin
                        // R23 - defaults restored
                        st_next.op_mode_reg = OP_MODE_RST;
                        st_next.rate_reg = RATE_CFG_RST;
                        st_next.route_reg = ROUTE_CFG_RST;
                        st_next.hold_reg = HOLD_CFG_RST;
                        st_next.idle_lo_reg = IDLE_RST;
                        st_next.idle_hi_reg = IDLE_RST;
                    end else begin
                        // R4 - wire mode stored
                        st_next.op_mode_reg = reg_req.wdata & OP_MODE_MASK;
                    end
                end
                ADDR_RATE_CFG: st_next.rate_reg = reg_req.wdata & RATE_CFG_MASK;
                ADDR_ROUTE_CFG: st_next.route_reg = reg_req.wdata;
                ADDR_HOLD_CFG: st_next.hold_reg = reg_req.wdata;
                ADDR_IDLE_LO: st_next.idle_lo_reg = reg_req.wdata;
                ADDR_IDLE_HI: st_next.idle_hi_reg = reg_req.wdata;
                default: ;
            endcase
        end

        // R1 - host mode select
        if (op_wr) begin
            st_next.idle_cnt = '0;
            st_next.idle_units = '0;
            if (soft_rst) begin
                st_next.op_state = AMC_DOWN;
            end else begin
                case (reg_req.wdata[1:0])
                    MODE_MEAS: st_next.op_state = AMC_MEAS;
                    MODE_WAKE: st_next.op_state = AMC_WAKE;
                    default: st_next.op_state = AMC_DOWN;
                endcase
            end
        end else begin
            unique case (st_reg.op_state)
                AMC_DOWN: ;
                AMC_WAKE: begin
                    // R8 - wake to measure
                    if (motion_detect && st_reg.op_mode_reg[1:0] == MODE_MEAS) begin
                        st_next.op_state = AMC_MEAS;
                        act_set = 1'b1;
                        st_next.idle_cnt = '0;
                        st_next.idle_units = '0;
                    end
                end
                AMC_MEAS: begin
                    if (motion_detect) begin
                        st_next.idle_cnt = '0;
                        st_next.idle_units = '0;
                    end else if (tick) begin
                        // R18 - 40 ms units
                        if (st_reg.idle_cnt >= 21'(IDLE_UNIT - 1)) begin
                            st_next.idle_cnt = '0;
                            st_next.idle_units = st_reg.idle_units + 16'h1;
                            // R9 - measure to wake
                            if (timeout != 16'h0 && st_reg.idle_units == timeout - 16'h1) begin
                                st_next.op_state = AMC_WAKE;
                                idle_set = 1'b1;
                                st_next.idle_units = '0;
                            end
                        end else begin
                            st_next.idle_cnt = st_reg.idle_cnt + 21'h1;
                        end
                    end
                end
            endcase
        end

        // Internal rate timer; stopped in power down and while sampling is external.
        if (st_reg.op_state == AMC_DOWN || st_reg.op_mode_reg[EXT_SAMPLE_BIT]) begin
            st_next.rate_cnt = '0;
        end else if (tick) begin
            if (st_reg.rate_cnt >= rate_period - 23'h1) begin
                st_next.rate_cnt = '0;
                rate_hit = 1'b1;
            end else begin
                st_next.rate_cnt = st_reg.rate_cnt + 23'h1;
            end
        end

        // R2 - external trigger sample
        if (st_reg.op_state != AMC_DOWN) begin
            st_next.sample_strobe = st_reg.op_mode_reg[EXT_SAMPLE_BIT] ? trig_edge : rate_hit;
        end

        // R7 - X capture gate
        if (x_sample_valid && st_reg.rate_reg[0]) begin
            st_next.x_value = x_sample_value;
        end

        // R22 - read clears flags
        st_next.act_flag = act_set || (st_reg.act_flag && !status_rd);
        st_next.idle_flag = idle_set || (st_reg.idle_flag && !status_rd);

        // Read data is registered, so it appears one cycle after the request.
        if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_IRQ_STATUS: begin
                    st_next.rdata = '0;
                    st_next.rdata[STS_ACT_BIT] = st_reg.act_flag;
                    st_next.rdata[STS_IDLE_BIT] = st_reg.idle_flag;
                end
                ADDR_MODE_STATUS: st_next.rdata = {5'h00, st_reg.op_state == AMC_MEAS,
                    st_reg.op_state == AMC_WAKE, st_reg.op_state == AMC_DOWN};
                ADDR_OP_MODE: st_next.rdata = st_reg.op_mode_reg;
                ADDR_RATE_CFG: st_next.rdata = st_reg.rate_reg;
                ADDR_ROUTE_CFG: st_next.rdata = st_reg.route_reg;
                ADDR_HOLD_CFG: st_next.rdata = st_reg.hold_reg;
                ADDR_IDLE_LO: st_next.rdata = st_reg.idle_lo_reg;
                ADDR_IDLE_HI: st_next.rdata = st_reg.idle_hi_reg;
                // R20 - low nibble layout
                ADDR_X_LO: st_next.rdata = {st_reg.x_value[3:0], 4'h0};
                // R21 - high byte layout
                ADDR_X_HI: st_next.rdata = st_reg.x_value[11:4];
                default: st_next.rdata = 8'h00;
            endcase
        end

        // R12 - pin polarity
        st_next.pin_out = pin_active ^ pin_pol;
        // A pin used as a clock or trigger input is released, never fought.
        st_next.pin_oe = {!st_reg.op_mode_reg[EXT_SAMPLE_BIT], !st_reg.op_mode_reg[EXT_CLOCK_BIT]};
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= AMC_CORE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flip-flops.
    assign reg_rdata = st_reg.rdata;
    assign sample_strobe = st_reg.sample_strobe;
    assign first_irq_pin_out = st_reg.pin_out[0];
    assign second_irq_pin_out = st_reg.pin_out[1];
    assign first_irq_pin_oe = st_reg.pin_oe[0];
    assign second_irq_pin_oe = st_reg.pin_oe[1];
    // R6 - filter control
    // R13 - range control
    assign cfg = '{ext_sample: st_reg.op_mode_reg[EXT_SAMPLE_BIT],
        ext_clock: st_reg.op_mode_reg[EXT_CLOCK_BIT],
        spi_three_wire: st_reg.op_mode_reg[SPI_WIRE_BIT],
        lowpass_enable: st_reg.rate_reg[LOWPASS_BIT],
        sample_rate_select: st_reg.rate_reg[6:4],
        z_capture_enable: st_reg.rate_reg[2],
        y_capture_enable: st_reg.rate_reg[1],
        x_capture_enable: st_reg.rate_reg[0],
        range_select: st_reg.route_reg[1:0],
        mode_select: st_reg.op_mode_reg[1:0]};

    chk_mode_meas_write: assert property (@(posedge core_clk) disable iff (!resetn) // R1
        (op_wr && !soft_rst && reg_req.wdata[1:0] == MODE_MEAS) |=> st_reg.op_state == AMC_MEAS)
        else $error("measurement mode not entered after write");

    chk_ext_trig_sample: assert property (@(posedge core_clk) disable iff (!resetn) // R2
        (st_reg.op_mode_reg[EXT_SAMPLE_BIT] && st_reg.op_state != AMC_DOWN && trig_edge)
        |=> sample_strobe)
        else $error("external trigger produced no sample");

    chk_ext_clock_hold: assert property (@(posedge core_clk) disable iff (!resetn) // R3
        (st_reg.op_mode_reg[EXT_CLOCK_BIT] && !clk_edge && !op_wr && !motion_detect
        && st_reg.op_state == AMC_MEAS) |=> $stable(st_reg.idle_cnt))
        else $error("idle count moved without an external clock edge");

    chk_wire_mode: assert property (@(posedge core_clk) disable iff (!resetn) // R4
        (op_wr && !soft_rst) |=> cfg.spi_three_wire == $past(reg_req.wdata[SPI_WIRE_BIT]))
        else $error("wire mode bit not taken from write");

    chk_act_event: assert property (@(posedge core_clk) disable iff (!resetn) // R8
        (st_reg.op_state == AMC_WAKE && !op_wr && motion_detect
        && st_reg.op_mode_reg[1:0] == MODE_MEAS) |=> st_reg.act_flag && st_reg.op_state == AMC_MEAS)
        else $error("activity not raised on wakeup exit");

    chk_idle_event: assert property (@(posedge core_clk) disable iff (!resetn) // R9
        (st_reg.op_state == AMC_MEAS && st_next.op_state == AMC_WAKE && !op_wr)
        |=> st_reg.idle_flag)
        else $error("inactivity not raised on measurement exit");

    chk_pin_polarity: assert property (@(posedge core_clk) disable iff (!resetn) // R12
        ##1 1'b1 |-> first_irq_pin_out == ($past(pin_active[0]) ^ $past(pin_pol[0])))
        else $error("pin one level does not follow polarity");

    chk_status_clear: assert property (@(posedge core_clk) disable iff (!resetn) // R22
        (status_rd && !act_set && !idle_set) |=> !st_reg.act_flag && !st_reg.idle_flag)
        else $error("status read left a source pending");

    chk_x_low_layout: assert property (@(posedge core_clk) disable iff (!resetn) // R20
        (reg_req.rd && reg_req.addr == ADDR_X_LO)
        |=> reg_rdata == {$past(st_reg.x_value[3:0]), 4'h0})
        else $error("X low byte layout wrong");

    chk_soft_reset: assert property (@(posedge core_clk) disable iff (!resetn) // R23
        soft_rst |=> st_reg.rate_reg == RATE_CFG_RST && st_reg.op_mode_reg == OP_MODE_RST)
        else $error("soft reset did not restore defaults");

endmodule : amc_mode_ctrl_regs

// ---- amc_pkg.sv ----
package amc_pkg;

    // Register offsets as printed for the serial port's register space.
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h01;
    localparam logic [7:0] ADDR_MODE_STATUS = 8'h02;
    localparam logic [7:0] ADDR_OP_MODE = 8'h08;
    localparam logic [7:0] ADDR_RATE_CFG = 8'h09;
    localparam logic [7:0] ADDR_ROUTE_CFG = 8'h0A;
    localparam logic [7:0] ADDR_HOLD_CFG = 8'h0B;
    localparam logic [7:0] ADDR_IDLE_LO = 8'h0D;
    localparam logic [7:0] ADDR_IDLE_HI = 8'h0E;
    localparam logic [7:0] ADDR_X_LO = 8'h10;
    localparam logic [7:0] ADDR_X_HI = 8'h11;

    // Values after reset and masks of the bits that can be stored.
    localparam logic [7:0] OP_MODE_RST = 8'h00;
    localparam logic [7:0] RATE_CFG_RST = 8'h07;
    localparam logic [7:0] ROUTE_CFG_RST = 8'h00;
    localparam logic [7:0] HOLD_CFG_RST = 8'h00;
    localparam logic [7:0] IDLE_RST = 8'h00;
    localparam logic [7:0] OP_MODE_MASK = 8'hE3;
    localparam logic [7:0] RATE_CFG_MASK = 8'h7F;

    // Field positions.
    localparam int EXT_SAMPLE_BIT = 7;
    localparam int EXT_CLOCK_BIT = 6;
    localparam int SPI_WIRE_BIT = 5;
    localparam int SOFT_RESET_BIT = 4;
    localparam int LOWPASS_BIT = 3;
    localparam int ACT_PIN_TWO_BIT = 7;
    localparam int IDLE_PIN_TWO_BIT = 6;
    localparam int ACT_PIN_ONE_BIT = 5;
    localparam int IDLE_PIN_ONE_BIT = 4;
    localparam int POL_PIN_TWO_BIT = 3;
    localparam int POL_PIN_ONE_BIT = 2;
    localparam int STS_ACT_BIT = 7;
    localparam int STS_IDLE_BIT = 0;

    // Operation mode codes and the fastest rate code.
    localparam logic [1:0] MODE_DOWN = 2'h0;
    localparam logic [1:0] MODE_WAKE = 2'h1;
    localparam logic [1:0] MODE_MEAS = 2'h2;
    localparam logic [2:0] RATE_MAX_CODE = 3'h6;
    localparam logic [3:0] HOLD_LATCHED = 4'h1;
    localparam logic [3:0] HOLD_FIRST_TIMED = 4'h2;

    // Times in nanoseconds and the derived counts of 40 MHz cycles.
    localparam int CLK_PERIOD_NS = 25;
    localparam int RATE_BASE_NS = 2500000;
    localparam int HOLD_BASE_NS = 2500000;
    localparam int PULSE_NS = 25000;
    localparam int IDLE_UNIT_NS = 40000000;
    localparam int RATE_BASE_CYC = RATE_BASE_NS / CLK_PERIOD_NS;
    localparam int HOLD_BASE_CYC = HOLD_BASE_NS / CLK_PERIOD_NS;
    localparam int PULSE_CYC = PULSE_NS / CLK_PERIOD_NS;
    localparam int IDLE_UNIT_CYC = IDLE_UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {AMC_DOWN, AMC_WAKE, AMC_MEAS} amc_state_t;

    // One register access taken from the serial port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amc_req_t;

    // Configuration seen by the sensing front end.
    typedef struct packed {
        logic ext_sample;
        logic ext_clock;
        logic spi_three_wire;
        logic lowpass_enable;
        logic [2:0] sample_rate_select;
        logic z_capture_enable;
        logic y_capture_enable;
        logic x_capture_enable;
        logic [1:0] range_select;
        logic [1:0] mode_select;
    } amc_cfg_t;

    // Whole state of the register bank.
    typedef struct packed {
        amc_state_t op_state;
        logic [7:0] op_mode_reg;
        logic [7:0] rate_reg;
        logic [7:0] route_reg;
        logic [7:0] hold_reg;
        logic [7:0] idle_lo_reg;
        logic [7:0] idle_hi_reg;
        logic act_flag;
        logic idle_flag;
        logic [11:0] x_value;
        logic [7:0] rdata;
        logic sample_strobe;
        logic [22:0] rate_cnt;
        logic [20:0] idle_cnt;
        logic [15:0] idle_units;
        logic [2:0] clk_sync;
        logic [2:0] trig_sync;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
    } amc_core_t;

    localparam amc_core_t AMC_CORE_RST = '{op_state: AMC_DOWN, rate_reg: RATE_CFG_RST,
        pin_oe: 2'h3, default: '0};

    // State of one interrupt pin's hold logic.
    typedef struct packed {
        logic active;
        logic [29:0] count;
    } amc_hold_t;

endpackage : amc_pkg

// ---- amc_pin_hold.sv ----
`timescale 1ns/10ps
module amc_pin_hold import amc_pkg::*; #(
    parameter int HOLD_BASE = HOLD_BASE_CYC
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Time base, event and clear.
    input wire logic tick,
    input wire logic event_in,
    input wire logic status_clear,
    input wire logic [3:0] hold_select,
    // Pin level before polarity.
    output logic active
);

    amc_hold_t st_reg;
    amc_hold_t st_next;

    // An event reloads the hold; it wins over a clear in the same cycle.
    always_comb begin
        st_next = st_reg;
        if (event_in) begin
            st_next.active = 1'b1;
            if (hold_select == 4'h0) begin
                // R16 - short pulse
                st_next.count = 30'(PULSE_CYC);
            end else if (hold_select == HOLD_LATCHED) begin
                st_next.count = '0;
            end else begin
                // R14 - doubling hold
                st_next.count = 30'(HOLD_BASE) << (hold_select - HOLD_FIRST_TIMED);
            end
        end else if (st_reg.active) begin
            if (hold_select == HOLD_LATCHED) begin
                // R15 - latched until read
                if (status_clear) begin
                    st_next.active = 1'b0;
                end
            end else if (tick) begin
                st_next.count = st_reg.count - 30'h1;
                if (st_reg.count <= 30'h1) begin
                    st_next.active = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign active = st_reg.active;

    chk_latch_holds: assert property (@(posedge core_clk) disable iff (!resetn) // R15
        (st_reg.active && hold_select == HOLD_LATCHED && !status_clear)
        |=> st_reg.active)
        else $error("latched pin released without a status read");

    chk_hold_load: assert property (@(posedge core_clk) disable iff (!resetn) // R14
        (event_in && hold_select >= HOLD_FIRST_TIMED)
        |=> st_reg.count == (30'(HOLD_BASE) << ($past(hold_select) - HOLD_FIRST_TIMED)))
        else $error("timed hold loaded with wrong length");

    chk_pulse_load: assert property (@(posedge core_clk) disable iff (!resetn) // R16
        (event_in && hold_select == 4'h0) |=> st_reg.active && st_reg.count == 30'(PULSE_CYC))
        else $error("non-latched pulse has wrong length");

endmodule : amc_pin_hold

// ---- amc_host.sv ----
`timescale 1ns/10ps
module amc_host import amc_pkg::*; (
    // Clock.
    input wire logic core_clk,
    // Requests toward the register bank.
    output amc_req_t reg_req
);
    logic [7:0] exp_q[$];

    initial reg_req = '0;

    // One request a cycle; an idle cycle scrambles the stale address and data.
    task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_req = '{w, r, a, d};
    endtask : acc

    task automatic wr(logic [7:0] a, logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask : rd

    task automatic idle();
        acc(1'b0, 1'b0, ~reg_req.addr, ~reg_req.wdata);
    endtask : idle
endmodule : amc_host

// ---- tb_amc_mode_ctrl_regs.sv ----
`timescale 1ns/10ps
module tb_amc_mode_ctrl_regs import amc_pkg::*; ();
    logic core_clk = 0, resetn = 0, motion_detect = 0, x_sample_valid = 0;
    logic lclk = 0, lrun = 0, trig = 0, rd_d = 0, sample_strobe;
    logic first_irq_pin_out, first_irq_pin_oe, second_irq_pin_out, second_irq_pin_oe;
    logic [11:0] x_sample_value = 0;
    logic [7:0] reg_rdata, d;
    logic [31:0] seed = 32'd78;
    logic [7:0] ra[9] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h05};
    logic [7:0] rv[9] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] rm[6] = '{8'hE3, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    int n_errors = 0, cmp_count = 0;
    amc_req_t reg_req;
    amc_cfg_t cfg;
    // Each pin level comes from the DUT while its enable is high, else from the testbench source.
    wire first_irq_pin_in = first_irq_pin_oe ? first_irq_pin_out : lclk;
    wire second_irq_pin_in = second_irq_pin_oe ? second_irq_pin_out : trig;

    amc_host amc_host_i (.core_clk, .reg_req);
    amc_mode_ctrl_regs #(.RATE_BASE(8), .HOLD_BASE(4), .IDLE_UNIT(5)) amc_mode_ctrl_regs_i (
        .core_clk, .resetn, .reg_req, .reg_rdata, .motion_detect, .x_sample_valid,
        .x_sample_value, .sample_strobe, .cfg, .first_irq_pin_in, .first_irq_pin_out,
        .first_irq_pin_oe, .second_irq_pin_in, .second_irq_pin_out, .second_irq_pin_oe);

    // Core clock; the link clock stands still outside its frame.
    always #12.5 core_clk = ~core_clk;
    initial #37 forever #100 lclk = lrun ? ~lclk : 1'b0;

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task automatic cmp(string n, logic [11:0] e, logic [11:0] s);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : cmp

    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Bounded wait for a pin or strobe level; running out ends the run.
    task automatic wait_on(string n, int k, logic e);
        logic s;
        for (int i = 0; i < 400; i++) begin
            @(posedge core_clk);
            #2;
            s = k ? sample_strobe : first_irq_pin_out;
            if (s === e) break;
        end
        cmp(n, e, s);
        if (s !== e) complete_run();
    endtask : wait_on

    // Read data shows one cycle after its request; the oldest note matches it.
    always @(posedge core_clk) begin
        if (rd_d)
            cmp("rdata", amc_host_i.exp_q.pop_front(), {4'h0, reg_rdata});
        rd_d <= reg_req.rd;
    end

    initial begin
        repeat (20) @(posedge core_clk);
        #1 resetn = 1;
        amc_host_i.wr(8'h11, 8'hFF);
        foreach (ra[i]) amc_host_i.rd(ra[i], rv[i]);
        // Random settings keep the mode field at power down and soft reset clear.
        // A live mode would raise stale events that later pin checks would see.
        for (int i = 0; i < 6; i++) begin
            d = rnd() & ((i == 0) ? 8'hEC : 8'hFF);
            amc_host_i.wr(ra[i], d);
            amc_host_i.rd(ra[i], d & rm[i]);
        end
        amc_host_i.wr(8'h08, 8'h10);
        foreach (ra[i]) amc_host_i.rd(ra[i], rv[i]);
        // A sample splits over both X bytes; a disabled axis keeps the old one.
        d = rnd();
        x_sample_value = {d[3:0], rnd()};
        x_sample_valid = 1;
        amc_host_i.rd(8'h10, {x_sample_value[3:0], 4'h0});
        x_sample_valid = 0;
        amc_host_i.rd(8'h11, x_sample_value[11:4]);
        amc_host_i.wr(8'h09, 8'h06);
        // The write lands one edge later, so the new sample must wait a cycle.
        amc_host_i.idle();
        x_sample_value = ~x_sample_value;
        x_sample_valid = 1;
        amc_host_i.rd(8'h11, ~x_sample_value[11:4]);
        x_sample_valid = 0;
        // Idle then motion, both routed to pin one with the latched hold.
        amc_host_i.wr(8'h0D, 8'h01);
        amc_host_i.wr(8'h0B, 8'h01);
        amc_host_i.wr(8'h0A, 8'h30);
        amc_host_i.wr(8'h08, 8'h02);
        amc_host_i.idle();
        wait_on("idle pin", 0, 1);
        amc_host_i.rd(8'h02, 8'h02);
        amc_host_i.rd(8'h01, 8'h01);
        amc_host_i.idle();
        wait_on("cleared pin", 0, 0);
        motion_detect = 1;
        wait_on("activity pin", 0, 1);
        amc_host_i.rd(8'h01, 8'h80);
        amc_host_i.rd(8'h02, 8'h04);
        amc_host_i.wr(8'h0A, 8'h34);
        amc_host_i.idle();
        wait_on("polarity", 0, 1);
        // External clock frame: pin one becomes an input.
        amc_host_i.wr(8'h08, 8'h42);
        amc_host_i.idle();
        lrun = 1;
        repeat (40) @(posedge core_clk);
        cmp("pin one oe", 0, first_irq_pin_oe);
        cmp("ext clock", 1, cfg.ext_clock);
        lrun = 0;
        amc_host_i.wr(8'h08, 8'h82);
        amc_host_i.idle();
        repeat (4) @(posedge core_clk);
        #1 trig = 1;
        wait_on("trigger strobe", 1, 1);
        complete_run();
    end
endmodule : tb_amc_mode_ctrl_regs
